// ### logic/plrp_blink.sv
// Activity blink generator: square wave while enabled, steady on otherwise
`timescale 1ns/100ps
module plrp_blink
  import plrp_pkg::*;
#(
  parameter int HALF_CYC = BLINK_HALF_CYC
)
(
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  output logic      phase_o
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        phase;
  } plrp_blink_s;

  plrp_blink_s st_reg;
  plrp_blink_s st_next;

  if (HALF_CYC < 2)
  begin : g_chk
    $error("plrp_blink: HALF_CYC must be at least 2");
  end

  always_comb
  begin
    st_next = st_reg;
    if (!en_i)
    begin
      // Idle restarts the cycle so the next burst starts with a visible off edge
      st_next.cnt   = 32'h0;
      st_next.phase = 1'b1;
    end
    else if (st_reg.cnt == 32'(HALF_CYC - 1))
    begin
      st_next.cnt   = 32'h0;
      st_next.phase = ~st_reg.phase;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_reg <= '{cnt: 32'h0, phase: 1'b1};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign phase_o = st_reg.phase;

endmodule // plrp_blink

// ### logic/plrp_pkg.sv
// Package of constants and types for the LED, reset and power-down pin block
package plrp_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 40;
  localparam int RST_MIN_NS     = 1000;
  localparam int RST_MIN_CYC    = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_HALF_NS  = 50000000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int STRAP_SETTLE   = 3;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  localparam int REG_W      = 16;
  localparam int IRQ_N      = 3;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [9:0] IDX_MULTI_PURPOSE_LED_CTRL = 10'h025;
  localparam logic [9:0] IDX_REGUL     = 10'h0d0;
  localparam logic [9:0] IDX_PIN_CTRL  = 10'h030;
  localparam logic [9:0] IDX_IRQ_STAT  = 10'h031;
  localparam logic [9:0] IDX_IRQ_MASK  = 10'h032;
  localparam logic [9:0] IDX_STRAPS    = 10'h033;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int MULTI_PURPOSE_LED_ROUTE_BIT   = 0;
  localparam int MULTI_PURPOSE_LED_MODE_BIT    = 1;
  localparam int REGUL_OFF_BIT    = 0;
  localparam int PIN_FUNC_IRQ_BIT = 0;
  localparam int STRAP_AN0_BIT    = 0;
  localparam int STRAP_ADDR0_BIT  = 1;
  localparam int IRQ_LINK_UP      = 0;
  localparam int IRQ_LINK_DOWN    = 1;
  localparam int IRQ_ACT          = 2;

  localparam logic [REG_W-1:0] MULTI_PURPOSE_LED_CTRL_RST = 16'h0000;
  localparam logic [REG_W-1:0] REGUL_RST     = 16'h0000;
  localparam logic [REG_W-1:0] PIN_CTRL_RST  = 16'h0000;
  localparam logic [IRQ_N-1:0] IRQ_MASK_RST  = 3'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE  = 3'h0,
    SEL_MULTI_PURPOSE_LED  = 3'h1,
    SEL_REGUL = 3'h2,
    SEL_PIN   = 3'h3,
    SEL_STAT  = 3'h4,
    SEL_MASK  = 3'h5,
    SEL_STRAP = 3'h6
  } plrp_sel_e;

  // Pin-side outputs that travel together
  typedef struct packed {
    logic link_status_led;
    logic col_pin;
    logic irq_or_sleep_out;
    logic irq_or_sleep_oe;
  } plrp_pins_s;

endpackage

// ### logic/plrp_top.sv
// LED output, LED routing, hardware reset, strap capture and shared interrupt/power-down pin
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/100ps

// Operation
// - In LED mode one the link LED is on while the link is up and off while it is down.
// - In LED mode two the LED is on while the link is up and blinks while there is transmit or receive activity.
// - The multi-purpose LED goes to the link LED pin or to the collision pin as the LED control register selects.
// - A low level on the hardware reset pin returns every register to its default value.
// - During a hardware reset the strap pins are sampled again and their options applied.
// - After reset the shared pin is a power-down input until a register write selects the interrupt function.
// - In power-down function a low level on the shared pin puts the device into power-down.
// - In interrupt function the shared pin is pulled low while an enabled interrupt is pending.
// - In interrupt function the shared pin is only ever driven low, never high.
// - A write to the regulator control register can switch off the internal regulator.
module plrp_top
  import plrp_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC
)
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  // AXI4-Lite slave
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [AXI_DATA_W-1:0] s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [AXI_DATA_W-1:0]      s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // Status from the transceiver core, same clock
  input  wire logic                  link_up_i,
  input  wire logic                  activity_i,
  input  wire logic                  collision_i,
  // Pins
  input  wire logic                  hw_reset_n_i,
  input  wire logic                  autoneg_strap_bit0_i,
  input  wire logic                  station_addr_strap_bit0_i,
  input  wire logic                  irq_or_sleep_in_i,
  output plrp_pins_s                 pins_o,
  // Core controls
  output logic                       power_down_o,
  output logic                       regulator_off_o,
  output logic                       autoneg_strap_o,
  output logic                       station_addr_strap_o,
  output logic                       irq_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0]            rst_sync;
    logic                  rst_n_flt;
    logic [2:0]            pd_sync;
    logic                  pd_n_flt;
    logic [2:0]            an_sync;
    logic                  an_flt;
    logic [2:0]            ad_sync;
    logic                  ad_flt;
    logic [1:0]            strap_cnt;
    logic                  an_strap;
    logic                  ad_strap;
    logic                  aw_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic                  w_got;
    logic [AXI_DATA_W-1:0] wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0]            rresp;
    logic [REG_W-1:0]      multi_purpose_led_ctrl;
    logic [REG_W-1:0]      regul;
    logic [REG_W-1:0]      pin_ctrl;
    logic [IRQ_N-1:0]      irq_stat;
    logic [IRQ_N-1:0]      irq_mask;
    logic                  link_q;
    logic                  act_q;
    plrp_pins_s            pins;
  } plrp_state_s;

  plrp_state_s st_reg;
  plrp_state_s st_next;

  logic blink_phase;
  logic led_sig;

  if (BLINK_CYC < 2)
  begin : g_chk
    $error("plrp_top: BLINK_CYC must be at least 2");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic plrp_sel_e decode(input logic [AXI_ADDR_W-1:0] addr);
    plrp_sel_e sel;
    unique case (addr[AXI_ADDR_W-1:2])
      IDX_MULTI_PURPOSE_LED_CTRL: sel = SEL_MULTI_PURPOSE_LED;
      IDX_REGUL:     sel = SEL_REGUL;
      IDX_PIN_CTRL:  sel = SEL_PIN;
      IDX_IRQ_STAT:  sel = SEL_STAT;
      IDX_IRQ_MASK:  sel = SEL_MASK;
      IDX_STRAPS:    sel = SEL_STRAP;
      default:       sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
                                               input logic [AXI_DATA_W-1:0] data,
                                               input logic [3:0] strb);
    logic [REG_W-1:0] res;
    res = old;
    if (strb[0])
    begin
      res[7:0] = data[7:0];
    end
    if (strb[1])
    begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Three-stage pin synchroniser; the filtered level moves only when stages two and three agree
  function automatic logic [3:0] sync3(input logic [2:0] sh, input logic flt, input logic pin);
    logic [2:0] nsh;
    logic       nflt;
    nsh  = {sh[1:0], pin};
    nflt = (sh[1] == sh[2]) ? sh[2] : flt;
    return {nsh, nflt};
  endfunction

  // ****************************************************************
  // Blink generator
  // ****************************************************************
  plrp_blink #(
    .HALF_CYC (BLINK_CYC)
  ) u_blink (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .en_i      (link_up_i & activity_i),
    .phase_o   (blink_phase)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    plrp_sel_e        wsel;
    plrp_sel_e        rsel;
    logic             do_wr;
    logic [IRQ_N-1:0] ev;
    logic [IRQ_N-1:0] w1c;
    logic             irq_pend;
    logic             route_col;
    st_next  = st_reg;
    wsel     = SEL_NONE;
    rsel     = SEL_NONE;
    do_wr    = 1'b0;
    ev       = '0;
    w1c      = '0;
    irq_pend = 1'b0;
    route_col = 1'b0;
    led_sig  = 1'b0;

    {st_next.rst_sync, st_next.rst_n_flt} = sync3(st_reg.rst_sync, st_reg.rst_n_flt, hw_reset_n_i);
    {st_next.pd_sync, st_next.pd_n_flt}   = sync3(st_reg.pd_sync, st_reg.pd_n_flt, irq_or_sleep_in_i);
    {st_next.an_sync, st_next.an_flt}     = sync3(st_reg.an_sync, st_reg.an_flt, autoneg_strap_bit0_i);
    {st_next.ad_sync, st_next.ad_flt}     = sync3(st_reg.ad_sync, st_reg.ad_flt, station_addr_strap_bit0_i);

    // Write channel: address and data taken in either order, response after both
    if (s_axi_awvalid_i && !st_reg.aw_got)
    begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !st_reg.w_got)
    begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata_i;
      st_next.wstrb = s_axi_wstrb_i;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
    begin
      wsel           = decode(st_reg.aw_addr);
      do_wr          = 1'b1;
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (st_reg.bvalid && s_axi_bready_i)
    begin
      st_next.bvalid = 1'b0;
    end

    if (do_wr)
    begin
      unique case (wsel)
        SEL_MULTI_PURPOSE_LED:  st_next.multi_purpose_led_ctrl = merge16(st_reg.multi_purpose_led_ctrl, st_reg.wdata, st_reg.wstrb);
        SEL_REGUL: st_next.regul     = merge16(st_reg.regul, st_reg.wdata, st_reg.wstrb);
        SEL_PIN:   st_next.pin_ctrl  = merge16(st_reg.pin_ctrl, st_reg.wdata, st_reg.wstrb);
        SEL_STAT:  w1c = st_reg.wdata[IRQ_N-1:0] & {IRQ_N{st_reg.wstrb[0]}};
        SEL_MASK:
        begin
          if (st_reg.wstrb[0])
          begin
            st_next.irq_mask = st_reg.wdata[IRQ_N-1:0];
          end
        end
        SEL_STRAP: ;
        SEL_NONE:  ;
      endcase
    end

    // Read channel: one word in flight, answer one cycle after the address is taken
    if (s_axi_arvalid_i && !st_reg.rvalid)
    begin
      rsel           = decode(s_axi_araddr_i);
      st_next.rvalid = 1'b1;
      st_next.rresp  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      st_next.rdata  = '0;
      unique case (rsel)
        SEL_MULTI_PURPOSE_LED:  st_next.rdata[REG_W-1:0] = st_reg.multi_purpose_led_ctrl;
        SEL_REGUL: st_next.rdata[REG_W-1:0] = st_reg.regul;
        SEL_PIN:   st_next.rdata[REG_W-1:0] = st_reg.pin_ctrl;
        SEL_STAT:  st_next.rdata[IRQ_N-1:0] = st_reg.irq_stat;
        SEL_MASK:  st_next.rdata[IRQ_N-1:0] = st_reg.irq_mask;
        SEL_STRAP:
        begin
          st_next.rdata[STRAP_AN0_BIT]   = st_reg.an_strap;
          st_next.rdata[STRAP_ADDR0_BIT] = st_reg.ad_strap;
        end
        SEL_NONE:  ;
      endcase
    end
    else if (st_reg.rvalid && s_axi_rready_i)
    begin
      st_next.rvalid = 1'b0;
    end

    // Interrupt events; a set in the same cycle as its clear wins
    st_next.link_q     = link_up_i;
    st_next.act_q      = activity_i;
    ev[IRQ_LINK_UP]    = link_up_i & ~st_reg.link_q;
    ev[IRQ_LINK_DOWN]  = ~link_up_i & st_reg.link_q;
    ev[IRQ_ACT]        = activity_i & ~st_reg.act_q;
    for (int i = 0; i < IRQ_N; i++)
    begin
      st_next.irq_stat[i] = ev[i] | (st_reg.irq_stat[i] & ~w1c[i]);
    end

    // Straps follow the pins while the reset pin is low and for a few cycles after power-on
    if (st_reg.strap_cnt != 2'h0)
    begin
      st_next.strap_cnt = st_reg.strap_cnt - 2'h1;
      st_next.an_strap  = st_reg.an_flt;
      st_next.ad_strap  = st_reg.ad_flt;
    end

    // Hardware reset pin overrides everything software did
    if (!st_reg.rst_n_flt)
    begin
      st_next.multi_purpose_led_ctrl = MULTI_PURPOSE_LED_CTRL_RST;
      st_next.regul     = REGUL_RST;
      st_next.pin_ctrl  = PIN_CTRL_RST;
      st_next.irq_mask  = IRQ_MASK_RST;
      st_next.irq_stat  = '0;
      st_next.strap_cnt = 2'(STRAP_SETTLE);
      st_next.an_strap  = st_reg.an_flt;
      st_next.ad_strap  = st_reg.ad_flt;
    end

    // LED function and routing, registered onto the pins
    if (st_reg.multi_purpose_led_ctrl[MULTI_PURPOSE_LED_MODE_BIT])
    begin
      led_sig = link_up_i & blink_phase;
    end
    else
    begin
      led_sig = link_up_i;
    end
    route_col = st_reg.multi_purpose_led_ctrl[MULTI_PURPOSE_LED_ROUTE_BIT];
    st_next.pins.link_status_led = route_col ? 1'b0 : led_sig;
    st_next.pins.col_pin         = route_col ? led_sig : collision_i;

    // Shared pin: open-drain low only, the weak pull-up supplies the high level
    irq_pend = |(st_reg.irq_stat & st_reg.irq_mask);
    st_next.pins.irq_or_sleep_out = 1'b0;
    st_next.pins.irq_or_sleep_oe  = st_reg.pin_ctrl[PIN_FUNC_IRQ_BIT] & irq_pend;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_reg           <= '0;
      // Power-on acts as a held reset pin until the synchroniser has seen the pin, so straps latch real levels
      st_reg.rst_sync  <= 3'h0;
      st_reg.rst_n_flt <= 1'b0;
      st_reg.pd_sync   <= 3'h7;
      st_reg.pd_n_flt  <= 1'b1;
      st_reg.strap_cnt <= 2'(STRAP_SETTLE);
      st_reg.multi_purpose_led_ctrl <= MULTI_PURPOSE_LED_CTRL_RST;
      st_reg.regul     <= REGUL_RST;
      st_reg.pin_ctrl  <= PIN_CTRL_RST;
      st_reg.irq_mask  <= IRQ_MASK_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready_o      = ~st_reg.aw_got;
  assign s_axi_wready_o       = ~st_reg.w_got;
  assign s_axi_bvalid_o       = st_reg.bvalid;
  assign s_axi_bresp_o        = st_reg.bresp;
  assign s_axi_arready_o      = ~st_reg.rvalid;
  assign s_axi_rvalid_o       = st_reg.rvalid;
  assign s_axi_rdata_o        = st_reg.rdata;
  assign s_axi_rresp_o        = st_reg.rresp;
  assign pins_o               = st_reg.pins;
  assign power_down_o         = ~st_reg.pin_ctrl[PIN_FUNC_IRQ_BIT] & ~st_reg.pd_n_flt;
  assign regulator_off_o      = st_reg.regul[REGUL_OFF_BIT];
  assign autoneg_strap_o      = st_reg.an_strap;
  assign station_addr_strap_o = st_reg.ad_strap;
  assign irq_o                = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule // plrp_top

// ### testbench/plrp_board.sv
// Board reset source and shared pin wiring with its pull-up
`timescale 1ns/100ps
module plrp_board
  import plrp_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_req_i,
  input  wire logic pd_low_i,
  input  wire logic pin_oe_i,
  output logic      hw_reset_n_o,
  output logic      pin_level_o
);
  int cnt = 0;
  // Request is stretched so the pin stays low past the minimum time
  always @(posedge clk_sys_i)
  begin
    if (rst_req_i)
      cnt <= RST_MIN_CYC + 2;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  assign hw_reset_n_o = (cnt == 0);
  // Open drain: any puller wins, otherwise the pull-up holds the wire high
  assign pin_level_o = !(pin_oe_i || pd_low_i);
endmodule // plrp_board

// ### testbench/plrp_props.sv
// Port-level checker for the LED, reset and power-down pin block
`timescale 1ns/100ps
module plrp_props
  import plrp_pkg::*;
(
  input wire logic                  clk_sys_i,
  input wire logic                  rst_i,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic                  s_axi_awvalid_i,
  input wire logic                  s_axi_awready_o,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0]            s_axi_wstrb_i,
  input wire logic                  s_axi_wvalid_i,
  input wire logic                  s_axi_wready_o,
  input wire logic                  s_axi_bvalid_o,
  input wire logic                  link_up_i,
  input wire logic                  activity_i,
  input wire logic                  hw_reset_n_i,
  input wire logic                  autoneg_strap_bit0_i,
  input wire logic                  station_addr_strap_bit0_i,
  input wire logic                  irq_or_sleep_in_i,
  input wire plrp_pins_s            pins_o,
  input wire logic                  power_down_o,
  input wire logic                  regulator_off_o,
  input wire logic                  autoneg_strap_o,
  input wire logic                  station_addr_strap_o,
  input wire logic                  irq_o
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic aw_w;
  logic wd0;
  assign aw_w = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  assign wd0  = s_axi_wdata_i[REGUL_OFF_BIT];

  chk_pin_never_high: assert property (!pins_o.irq_or_sleep_out)
    else $error("shared pin driven high");
  chk_oe_has_cause: assert property (pins_o.irq_or_sleep_oe |-> $past(irq_o))
    else $error("shared pin pulled low without interrupt");
  chk_pd_no_oe: assert property (power_down_o |=> !pins_o.irq_or_sleep_oe)
    else $error("pin pulled low while in power-down function");
  chk_led_no_link: assert property (!link_up_i |=> !pins_o.link_status_led)
    else $error("link led on without link");
  chk_pd_cause: assert property (power_down_o |-> !$past(irq_or_sleep_in_i, 3) || !$past(irq_or_sleep_in_i, 4))
    else $error("power-down without low pin");
  chk_hwrst_clear: assert property ((!hw_reset_n_i)[*8] |-> !regulator_off_o && !irq_o)
    else $error("registers not cleared by hardware reset");
  chk_strap_load: assert property ((!hw_reset_n_i && $stable(autoneg_strap_bit0_i)
    && $stable(station_addr_strap_bit0_i))[*8] |-> autoneg_strap_o == autoneg_strap_bit0_i
    && station_addr_strap_o == station_addr_strap_bit0_i)
    else $error("straps not sampled during hardware reset");
  chk_reg_off_wr: assert property (aw_w && s_axi_awaddr_i == {IDX_REGUL, 2'b00} && s_axi_wstrb_i[0]
    |-> ##2 regulator_off_o == $past(wd0, 2))
    else $error("regulator write not applied");
  chk_b_timing: assert property (aw_w |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  cov_oe: cover property (pins_o.irq_or_sleep_oe);
  cov_blink: cover property (activity_i && $fell(pins_o.link_status_led));
  cov_pd: cover property ($rose(power_down_o));
endmodule // plrp_props

bind plrp_top plrp_props chk_u (.*);

// ### testbench/tb_top.sv
// Self-checking testbench of the LED, reset and power-down pin block
`timescale 1ns/100ps
module tb_top
  import plrp_pkg::*;
;
  localparam int BLINK = 8;
  localparam logic [11:0] A_MULTI_PURPOSE_LED = {IDX_MULTI_PURPOSE_LED_CTRL, 2'b00};
  localparam logic [11:0] A_REGUL = {IDX_REGUL, 2'b00};
  localparam logic [11:0] A_PIN = {IDX_PIN_CTRL, 2'b00};
  localparam logic [11:0] A_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_STRAP = {IDX_STRAPS, 2'b00};
  localparam logic [11:0] REGS [6] = '{A_MULTI_PURPOSE_LED, A_REGUL, A_PIN, A_STAT, A_MASK, A_STRAP};
  logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [3:0] ws = 0;
  logic [1:0] bresp, rresp;
  logic awr, wr, bv, arr, rv, pd, regoff, sa_o, sb_o, irq, hwn, pin;
  logic link = 0, act = 0, col = 0, sa = 1, sb = 0, pd_low = 0, rst_req = 0;
  plrp_pins_s pins;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'hc0d6;

  initial
  begin
    forever #20 clk = ~clk;
  end

  plrp_top #(.BLINK_CYC(BLINK)) dut_u (.clk_sys_i(clk), .rst_i(rst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(bre), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
    .link_up_i(link), .activity_i(act), .collision_i(col), .hw_reset_n_i(hwn),
    .autoneg_strap_bit0_i(sa), .station_addr_strap_bit0_i(sb), .irq_or_sleep_in_i(pin),
    .pins_o(pins), .power_down_o(pd), .regulator_off_o(regoff), .autoneg_strap_o(sa_o),
    .station_addr_strap_o(sb_o), .irq_o(irq));
  plrp_board brd_u (.clk_sys_i(clk), .rst_req_i(rst_req), .pd_low_i(pd_low),
    .pin_oe_i(pins.irq_or_sleep_oe), .hw_reset_n_o(hwn), .pin_level_o(pin));

  // ****
  // Tasks
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected {link pin, collision pin} for a routing choice
  function automatic logic [1:0] exp_route(input logic to_col, input logic led, input logic coll);
    return to_col ? {1'b0, led} : {led, coll};
  endfunction
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    $display("unexpected at %0t: wait timed out", $time);
    final_report();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // The master keeps bready up from the start; the slave must answer within 50 cycles
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= 4'h3;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    done = 0;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wr)
        wv <= 1'b0;
      if (bv)
      begin
        check(bresp, er);
        done = 1;
      end
    end
    bre <= 1'b0;
    if (!done)
      hang();
  endtask
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    done = 0;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(posedge clk);
      if (arr)
        arv <= 1'b0;
      if (rv)
      begin
        d = rd;
        r = rresp;
        done = 1;
      end
    end
    rre <= 1'b0;
    if (!done)
      hang();
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(r, RESP_OKAY);
    check(d, e);
  endtask

  // ****
  // Main sequence
  // ****
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    int t;
    logic prev;
    tick(5);
    rst <= 1'b0;
    tick(8);
    for (int i = 0; i < 5; i++)
      rd_chk(REGS[i], 32'h0);
    rd_chk(A_STRAP, 32'h1);
    check({pins, pd, regoff, irq}, 0);
    axi_wr(12'h004, 32'hffff, RESP_SLVERR);
    axi_rd(12'h004, d, r);
    check(r, RESP_SLVERR);
    axi_wr(A_MULTI_PURPOSE_LED, 32'h0, RESP_OKAY);
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      link <= seed[0];
      act <= seed[1];
      tick(3);
      check(pins.link_status_led, seed[0]);
    end
    axi_wr(A_MULTI_PURPOSE_LED, 32'h2, RESP_OKAY);
    link <= 1'b1;
    act <= 1'b1;
    tick(3);
    t = 0;
    prev = pins.link_status_led;
    repeat (64)
    begin
      @(posedge clk);
      t += (pins.link_status_led !== prev);
      prev = pins.link_status_led;
    end
    check(t >= 64 / BLINK - 1 && t <= 64 / BLINK + 1, 1);
    act <= 1'b0;
    tick(3);
    check(pins.link_status_led, 1);
    axi_wr(A_MULTI_PURPOSE_LED, 32'h0, RESP_OKAY);
    col <= 1'b1;
    tick(3);
    check({pins.link_status_led, pins.col_pin}, exp_route(1'b0, 1'b1, 1'b1));
    axi_wr(A_MULTI_PURPOSE_LED, 32'h1, RESP_OKAY);
    col <= 1'b0;
    tick(3);
    check({pins.link_status_led, pins.col_pin}, exp_route(1'b1, 1'b1, 1'b0));
    for (int v = 1; v >= 0; v--)
    begin
      axi_wr(A_REGUL, v, RESP_OKAY);
      check(regoff, v);
      rd_chk(A_REGUL, v);
    end
    pd_low <= 1'b1;
    tick(6);
    check(pd, 1);
    pd_low <= 1'b0;
    tick(6);
    check(pd, 0);
    // Status is sticky, so earlier link traffic is cleared before the real event
    axi_wr(A_PIN, 32'h1, RESP_OKAY);
    axi_wr(A_STAT, 32'h7, RESP_OKAY);
    axi_wr(A_MASK, 32'h1 << IRQ_LINK_UP, RESP_OKAY);
    link <= 1'b0;
    tick(3);
    link <= 1'b1;
    tick(3);
    check({irq, pin, pd}, 3'b100);
    rd_chk(A_STAT, 32'h3);
    axi_wr(A_MASK, 32'h0, RESP_OKAY);
    tick(2);
    check({irq, pin}, 2'b01);
    axi_wr(A_MASK, 32'h7, RESP_OKAY);
    tick(2);
    check({irq, pin}, 2'b10);
    axi_wr(A_STAT, 32'h7, RESP_OKAY);
    tick(2);
    check({irq, pin}, 2'b01);
    axi_wr(A_MULTI_PURPOSE_LED, 32'h3, RESP_OKAY);
    axi_wr(A_REGUL, 32'h1, RESP_OKAY);
    seed = lfsr(seed);
    sa <= seed[0];
    sb <= seed[1];
    rst_req <= 1'b1;
    @(posedge clk);
    rst_req <= 1'b0;
    t = 0;
    for (int n = 0; n < 100 && t == 0; n++)
    begin
      @(posedge clk);
      t = hwn;
    end
    if (t == 0)
      hang();
    tick(10);
    check({sa_o, sb_o, regoff}, {seed[0], seed[1], 1'b0});
    for (int i = 0; i < 5; i++)
      rd_chk(REGS[i], 32'h0);
    rd_chk(A_STRAP, {seed[1], seed[0]});
    final_report();
  end
endmodule // tb_top
